// File: bench/ccrc_station_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccrc_station_model #(
  parameter logic [4:0] PRTAD = 5'h05
) (
  input wire logic clk,
  input wire logic mdio_out,
  input wire logic mdio_oe,
  output logic mdc,
  output wire logic mdio_in
);
  logic drv;
  logic dout;
  logic smp;
  // A released line floats to the pull-up level
  assign mdio_in = mdio_oe ? mdio_out : (drv ? dout : 1'b1);
  initial begin
    mdc = 1'b0;
    drv = 1'b0;
    dout = 1'b1;
  end
  // Clock stands low between frames; data moves only while it is low
  task automatic bit_io(input logic en, input logic b);
    drv = en;
    dout = b;
    repeat (4) @(negedge clk);
    mdc = 1'b1;
    smp = mdio_in;
    repeat (4) @(negedge clk);
    mdc = 1'b0;
  endtask : bit_io
  // Each frame carries its own preamble; reads release the line from turnaround on
  task automatic frame(input logic [1:0] op, input logic [4:0] dev, input logic [15:0] d,
                       output logic [15:0] q);
    logic [31:0] f;
    f = {2'h0, op, PRTAD, dev, 2'h2, d};
    q = 16'h0000;
    for (int i = 0; i < 32; i++) bit_io(1'b1, 1'b1);
    for (int i = 31; i >= 0; i--) begin
      bit_io(!op[1] || i > 17, f[i]);
      q = {q[14:0], smp};
    end
    drv = 1'b0;
    @(negedge clk);
  endtask : frame
endmodule : ccrc_station_model
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ccrc_pkg::*;
  localparam logic [4:0] PORT = 5'h05;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mdc;
  wire logic mdio_in;
  logic mdio_out, mdio_oe, reported_lane_status, link_status, forced_lane_realign;
  logic datapath_reset, transmit_buffer_reset, receive_buffer_reset;
  logic outclk_driver_off, outclk_p, outclk_n;
  logic [4:0] port_address = PORT;
  logic [3:0] lane_status = 4'h1;
  logic [3:0] lane_enable = 4'hF;
  logic [3:0] lane_signal_loss = 4'h0;
  logic lowside_pll_lock = 1'b1;
  logic core_link_ok = 1'b1;
  logic plain_10g_mode = 1'b0;
  logic [SRC_COUNT-1:0] source_clocks = 5'h00;
  logic [2:0] seen = 3'h0;
  logic seen_clr = 1'b0;
  int cnt = 0;
  int checks = 0;
  int fails = 0;
  int dcode [9] = '{0, 4, 8, 9, 10, 12, 13, 14, 15};
  int drat [9] = '{1, 2, 4, 8, 16, 5, 10, 20, 25};
  int sidx [8] = '{0, 1, 0, 1, 2, 2, 3, 4};

  always #20 clk = ~clk;
  // Source k has a period of 2(k+1) clocks, so each selection is told apart
  always @(negedge clk) begin
    cnt++;
    for (int k = 0; k < SRC_COUNT; k++) source_clocks[k] = (cnt % (2 * k + 2)) < (k + 1);
  end
  // Short reset pulses are caught here and inspected later
  always @(posedge clk) begin
    if (seen_clr) seen <= 3'h0;
    else seen <= seen | {datapath_reset, transmit_buffer_reset, receive_buffer_reset};
  end

  ccrc_top ccrc_top_i (
    .clk, .rst, .mdc, .mdio_in, .mdio_out, .mdio_oe, .port_address,
    .lane_status, .lane_enable, .lane_signal_loss, .lowside_pll_lock, .core_link_ok,
    .plain_10g_mode, .source_clocks, .reported_lane_status, .link_status,
    .forced_lane_realign, .datapath_reset, .transmit_buffer_reset, .receive_buffer_reset,
    .outclk_driver_off, .outclk_p, .outclk_n
  );
  ccrc_station_model #(.PRTAD(PORT)) ccrc_station_model_i (
    .clk, .mdio_out, .mdio_oe, .mdc, .mdio_in
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    logic [15:0] q;
    ccrc_station_model_i.frame(OP_ADDR, MGMT_DEVAD, a, q);
    ccrc_station_model_i.frame(OP_WRITE, MGMT_DEVAD, d, q);
    repeat (4) @(negedge clk);
  endtask : wr
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] q;
    ccrc_station_model_i.frame(OP_ADDR, MGMT_DEVAD, a, q);
    ccrc_station_model_i.frame(2'h3, MGMT_DEVAD, 16'h0000, q);
    check(q, e);
  endtask : rd_chk
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask : settle
  // First period after a change may be short, so the second full one is counted
  task automatic meas(output logic [15:0] p);
    int r;
    logic prev;
    r = 0;
    p = 16'h0000;
    prev = outclk_p;
    for (int i = 0; i < 400 && r < 3; i++) begin
      @(negedge clk);
      if (r > 1) p++;
      if (outclk_p && !prev) r++;
      prev = outclk_p;
    end
  endtask : meas
  task automatic quiet(output logic [1:0] a);
    a = 2'h0;
    repeat (10) @(negedge clk);
    repeat (60) @(negedge clk) a = a | {outclk_p, outclk_n};
  endtask : quiet
  task automatic end_of_test();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    end_of_test();
  end

  initial begin
    logic [15:0] p;
    logic [1:0] a;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    rd_chk(LOWSIDE_OFFSET, 16'h0330);
    rd_chk(OUTCLK_OFFSET, 16'h2F80);
    rd_chk(SOFTRST_OFFSET, 16'h0000);
    ccrc_station_model_i.frame(OP_ADDR, MGMT_DEVAD, LOWSIDE_OFFSET, p);
    ccrc_station_model_i.frame(OP_READ_INC, MGMT_DEVAD, 16'h0000, p);
    check(p, 16'h0330);
    ccrc_station_model_i.frame(2'h3, MGMT_DEVAD, 16'h0000, p);
    check(p, 16'h2F80);
    check(link_status, 1'b1);
    check(reported_lane_status, 1'b1);
    meas(p);
    check(p, 16'h0008);
    wr(16'h000F, 16'hFFFF);
    rd_chk(16'h000F, 16'h0000);
    ccrc_station_model_i.frame(OP_ADDR, 5'h1D, LOWSIDE_OFFSET, p);
    ccrc_station_model_i.frame(OP_WRITE, 5'h1D, 16'h0000, p);
    rd_chk(LOWSIDE_OFFSET, 16'h0330);
    wr(LOWSIDE_OFFSET, 16'hFFFF);
    rd_chk(LOWSIDE_OFFSET, 16'hF3F7);
    check(forced_lane_realign, 1'b1);
    for (int s = 0; s < 4; s++) begin
      wr(LOWSIDE_OFFSET, 16'(s) << 12);
      check(forced_lane_realign, 1'b0);
      lane_status = 4'h1 << s;
      settle();
      check(reported_lane_status, 1'b1);
      lane_status = ~(4'h1 << s);
      settle();
      check(reported_lane_status, 1'b0);
    end
    lane_signal_loss = 4'h2;
    lowside_pll_lock = 1'b0;
    for (int m = 0; m < 4; m++) begin
      wr(LOWSIDE_OFFSET, 16'(m) << 4);
      check(link_status, m == 3);
    end
    lane_enable = 4'hD;
    wr(LOWSIDE_OFFSET, 16'h0010);
    check(link_status, 1'b1);
    core_link_ok = 1'b0;
    settle();
    check(link_status, 1'b0);
    core_link_ok = 1'b1;
    lowside_pll_lock = 1'b1;
    wr(LOWSIDE_OFFSET, 16'h0000);
    check(link_status, 1'b1);
    // Only documented divider and source codes are sent
    for (int i = 0; i < 9; i++) begin
      wr(OUTCLK_OFFSET, 16'h2000 | (16'(dcode[i]) << 4));
      meas(p);
      check(p, 16'(drat[i] * 2));
    end
    for (int i = 0; i < 8; i++) begin
      wr(OUTCLK_OFFSET, 16'h2000 | 16'(i));
      meas(p);
      check(p, 16'(sidx[i] * 2 + 2));
    end
    check(outclk_n, !outclk_p);
    wr(OUTCLK_OFFSET, 16'h0F80);
    quiet(a);
    check(a, 2'h1);
    wr(OUTCLK_OFFSET, 16'h3F80);
    check(outclk_driver_off, 1'b1);
    quiet(a);
    check(a, 2'h0);
    rd_chk(OUTCLK_OFFSET, 16'h3F80);
    wr(OUTCLK_OFFSET, 16'h2F80);
    check(outclk_driver_off, 1'b0);
    // Datapath reset only after the mode is configured
    plain_10g_mode = 1'b1;
    wr(LOWSIDE_OFFSET, 16'h0330);
    seen_clr = 1'b1;
    @(negedge clk) seen_clr = 1'b0;
    wr(SOFTRST_OFFSET, 16'h000E);
    rd_chk(SOFTRST_OFFSET, 16'h0000);
    check(seen, 3'h7);
    rd_chk(LOWSIDE_OFFSET, 16'h0330);
    plain_10g_mode = 1'b0;
    seen_clr = 1'b1;
    @(negedge clk) seen_clr = 1'b0;
    wr(SOFTRST_OFFSET, 16'h0006);
    rd_chk(SOFTRST_OFFSET, 16'h0000);
    check(seen, 3'h0);
    wr(SOFTRST_OFFSET, 16'hFFFF);
    rd_chk(SOFTRST_OFFSET, 16'h00F1);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire

// File: hdl/ccrc_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
module ccrc_clk_div #(
  parameter int CW = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic src_level,
  input wire logic src_rise,
  input wire logic [CW-1:0] ratio,
  output logic level
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic level;
  } ccrc_div_type;

  ccrc_div_type st, next_st;
  logic [CW-1:0] cnt_inc;

  if (CW < 5) begin : g_bad_width
    $error("ccrc_clk_div needs CW of at least 5 for divide by 25");
  end

  assign cnt_inc = (st.cnt == ratio - 1'b1) ? '0 : st.cnt + 1'b1;

  always_comb begin
    next_st = st;
    if (ratio == 1'b1) begin
      next_st.level = src_level;
    end else if (ratio != '0 && src_rise) begin
      // Odd ratios run high one source cycle longer than low
      next_st.cnt = cnt_inc;
      next_st.level = cnt_inc < ((ratio + 1'b1) >> 1);
    end
    // Reserved codes freeze the output at its last level
    if (rst) next_st = '0;
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign level = st.level;

  chk_reserved_hold: assert property (@(posedge clk) disable iff (rst)
    ratio == '0 |=> $stable(level))
    else $error("output moved on a reserved divider code");
endmodule : ccrc_clk_div
`default_nettype wire

// File: hdl/ccrc_mdio_slave.sv
`timescale 1ns/1ps
`default_nettype none
module ccrc_mdio_slave (
  input wire logic clk,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] port_address,
  ccrc_mgmt_if.engine mgmt
);
  import ccrc_pkg::*;

  typedef struct packed {
    logic mdc_s1, mdc_s2, mdc_s3;
    logic dio_s1, dio_s2;
    logic [4:0] pa_s1, pa_s2;
    ccrc_mdio_state_type state;
    logic [5:0] cnt;
    logic [15:0] shreg;
    logic [1:0] op;
    logic hit;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic dout;
    logic oe;
  } ccrc_mdio_type;

  ccrc_mdio_type st, next_st;
  logic rise;
  logic [13:0] hdr;
  logic [15:0] word;

  // Pins and straps are only read after two flops
  assign rise = st.mdc_s2 & ~st.mdc_s3;
  assign hdr = {st.shreg[12:0], st.dio_s2};
  assign word = {st.shreg[14:0], st.dio_s2};

  always_comb begin
    next_st = st;
    next_st.wr = 1'b0;
    next_st.mdc_s1 = mdc;
    next_st.mdc_s2 = st.mdc_s1;
    next_st.mdc_s3 = st.mdc_s2;
    next_st.dio_s1 = mdio_in;
    next_st.dio_s2 = st.dio_s1;
    next_st.pa_s1 = port_address;
    next_st.pa_s2 = st.pa_s1;
    if (rise) begin
      case (st.state)
        MDIO_PRE: begin
          if (st.dio_s2) begin
            if (st.cnt != PREAMBLE_BITS) next_st.cnt = st.cnt + 6'h01;
          end else if (st.cnt == PREAMBLE_BITS) begin
            next_st.state = MDIO_HDR;
            next_st.cnt = 6'h01;
            next_st.shreg = '0;
          end else begin
            next_st.cnt = '0;
          end
        end
        MDIO_HDR: begin
          next_st.shreg = word;
          next_st.cnt = st.cnt + 6'h01;
          if (st.cnt == HDR_BITS - 6'h01) begin
            next_st.state = MDIO_TA;
            next_st.cnt = '0;
            next_st.op = hdr[11:10];
            next_st.hit = (hdr[13:12] == 2'h0) && (hdr[9:5] == st.pa_s2)
                          && (hdr[4:0] == MGMT_DEVAD);
            if (hdr[11]) next_st.shreg = mgmt.rdata;
            if (hdr[11:10] == OP_READ_INC && next_st.hit) begin
              next_st.addr = st.addr + 16'h0001;
            end
          end
        end
        MDIO_TA: begin
          next_st.cnt = st.cnt + 6'h01;
          if (st.cnt == 6'h00) begin
            next_st.oe = st.hit & st.op[1];
            next_st.dout = 1'b0;
          end else begin
            next_st.state = MDIO_DATA;
            next_st.cnt = '0;
            next_st.dout = st.shreg[15];
            next_st.shreg = word;
          end
        end
        MDIO_DATA: begin
          next_st.shreg = word;
          next_st.dout = st.shreg[15];
          next_st.cnt = st.cnt + 6'h01;
          if (st.cnt == DATA_BITS - 6'h01) begin
            next_st.state = MDIO_PRE;
            next_st.cnt = '0;
            next_st.oe = 1'b0;
            if (st.hit && st.op == OP_WRITE) begin
              next_st.wdata = word;
              next_st.wr = 1'b1;
            end
            if (st.hit && st.op == OP_ADDR) next_st.addr = word;
          end
        end
        default: next_st.state = MDIO_PRE;
      endcase
    end
    if (rst) begin
      next_st = '0;
      next_st.state = MDIO_PRE;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign mdio_out = st.dout;
  assign mdio_oe = st.oe;
  assign mgmt.addr = st.addr;
  assign mgmt.wdata = st.wdata;
  assign mgmt.wr = st.wr;
  assign mgmt.mdc_rise = rise;

  chk_drive_own_devad: assert property (@(posedge clk) disable iff (rst)
    mdio_oe |-> st.hit && st.op[1])
    else $error("mdio driven for a frame not addressed here");
endmodule : ccrc_mdio_slave
`default_nettype wire

// File: hdl/ccrc_mgmt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ccrc_mgmt_if;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic wr;
  logic mdc_rise;
  modport engine (output addr, output wdata, output wr, output mdc_rise, input rdata);
  modport bank (input addr, input wdata, input wr, input mdc_rise, output rdata);
endinterface : ccrc_mgmt_if
`default_nettype wire

// File: hdl/ccrc_pkg.sv
package ccrc_pkg;
  localparam int LANES = 4;
  localparam logic [4:0] MGMT_DEVAD = 5'h1E;
  localparam logic [15:0] LOWSIDE_OFFSET = 16'h000C;
  localparam logic [15:0] OUTCLK_OFFSET = 16'h000D;
  localparam logic [15:0] SOFTRST_OFFSET = 16'h000E;
  localparam logic [15:0] LOWSIDE_RESET = 16'h0330;
  localparam logic [15:0] OUTCLK_RESET = 16'h2F80;
  localparam logic [15:0] SOFTRST_RESET = 16'h0000;
  localparam logic [15:0] LOWSIDE_KEEP = 16'hF3F7;
  localparam logic [15:0] OUTCLK_KEEP = 16'h3FFF;
  localparam logic [15:0] SOFTRST_KEEP = 16'h00FF;
  localparam logic [15:0] SOFTRST_SELF_CLEAR = 16'h000E;
  localparam int LANE_SEL_LSB = 12;
  localparam int LOS_IGNORE_BIT = 5;
  localparam int LOCK_IGNORE_BIT = 4;
  localparam int REALIGN_BIT = 2;
  localparam int TOGGLE_EN_BIT = 13;
  localparam int DRIVER_OFF_BIT = 12;
  localparam int DIV_LSB = 4;
  localparam int SRC_LSB = 0;
  localparam int DATAPATH_RST_BIT = 3;
  localparam int TX_BUF_RST_BIT = 2;
  localparam int RX_BUF_RST_BIT = 1;
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [5:0] HDR_BITS = 6'h0E;
  localparam logic [5:0] DATA_BITS = 6'h10;
  localparam logic [1:0] OP_ADDR = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ_INC = 2'h2;
  localparam int SRC_COUNT = 5;
  localparam logic [2:0] SRC_NONE = 3'h5;

  typedef enum logic [3:0] {
    MDIO_PRE = 4'b0001,
    MDIO_HDR = 4'b0010,
    MDIO_TA = 4'b0100,
    MDIO_DATA = 4'b1000
  } ccrc_mdio_state_type;

  // Zero marks a reserved code; the divider then holds its output
  function automatic logic [4:0] ccrc_div_ratio(input logic [3:0] code);
    case (code)
      4'h0: ccrc_div_ratio = 5'h01;
      4'h4: ccrc_div_ratio = 5'h02;
      4'h8: ccrc_div_ratio = 5'h04;
      4'h9: ccrc_div_ratio = 5'h08;
      4'hA: ccrc_div_ratio = 5'h10;
      4'hC: ccrc_div_ratio = 5'h05;
      4'hD: ccrc_div_ratio = 5'h0A;
      4'hE: ccrc_div_ratio = 5'h14;
      4'hF: ccrc_div_ratio = 5'h19;
      default: ccrc_div_ratio = 5'h00;
    endcase
  endfunction : ccrc_div_ratio

  // Index 0 hs recovered, 1 hs transmit, 2 hs vco/4, 3 ls recovered, 4 ls transmit
  function automatic logic [2:0] ccrc_src_index(input logic [3:0] code);
    casez (code)
      4'b00?0: ccrc_src_index = 3'h0;
      4'b00?1: ccrc_src_index = 3'h1;
      4'b010?: ccrc_src_index = 3'h2;
      4'b0110: ccrc_src_index = 3'h3;
      4'b0111: ccrc_src_index = 3'h4;
      default: ccrc_src_index = SRC_NONE;
    endcase
  endfunction : ccrc_src_index
endpackage : ccrc_pkg

// File: hdl/ccrc_top.sv
// Notes on behaviour
// - Bits 13:12 pick the reported lane
// - Low-side bits 11:10 and 3 read zero
// - Bit 5 set drops lane loss from link
// - Bit 4 set drops pll lock from link
// - Bit 2 forces lane realignment in monitor
// - Bit 13 clear freezes the output clock
// - Bit 12 set powers down clock driver
// - Divider codes give 1, 2, 4, 8, 16
// - Codes 1100 to 1111 give 5..25
// - Source codes 0000 to 0101 pick high-speed clocks
// - Codes 0110, 0111 pick low-speed clocks
// - Reset bits self-clear next mdc cycle
// - Datapath reset spares management registers
// - Bit 2 resets transmit buffer, 10G only
// - Bit 1 resets receive buffer, 10G only
// - KR mode buffers self-centre, no reset
// - Device 0x1E, resets 0330, 2F80, 0000
`timescale 1ns/1ps
`default_nettype none
module ccrc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] port_address,
  input wire logic [ccrc_pkg::LANES-1:0] lane_status,
  input wire logic [ccrc_pkg::LANES-1:0] lane_enable,
  input wire logic [ccrc_pkg::LANES-1:0] lane_signal_loss,
  input wire logic lowside_pll_lock,
  input wire logic core_link_ok,
  input wire logic plain_10g_mode,
  input wire logic [ccrc_pkg::SRC_COUNT-1:0] source_clocks,
  output logic reported_lane_status,
  output logic link_status,
  output logic forced_lane_realign,
  output logic datapath_reset,
  output logic transmit_buffer_reset,
  output logic receive_buffer_reset,
  output logic outclk_driver_off,
  output logic outclk_p,
  output logic outclk_n
);
  import ccrc_pkg::*;

  typedef struct packed {
    logic [15:0] lowside;
    logic [15:0] outclk;
    logic [15:0] softrst;
    logic [SRC_COUNT-1:0] src_s1, src_s2, src_s3;
    logic rep;
    logic link;
    logic realign;
    logic dp_rst;
    logic tx_rst;
    logic rx_rst;
    logic drv_off;
    logic pin_p;
    logic pin_n;
  } ccrc_bank_type;

  ccrc_bank_type bank, next_bank;
  ccrc_mgmt_if mgmt ();
  logic [2:0] src_idx;
  logic [4:0] ratio;
  logic sel_level;
  logic sel_rise;
  logic div_level;
  logic [1:0] lane_sel;
  logic los_ok;
  logic lock_ok;

  ccrc_mdio_slave u_mdio (
    .clk(clk),
    .rst(rst),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .port_address(port_address),
    .mgmt(mgmt.engine)
  );

  // Unmapped offsets read as zero
  always_comb begin
    case (mgmt.addr)
      LOWSIDE_OFFSET: mgmt.rdata = bank.lowside & LOWSIDE_KEEP;
      OUTCLK_OFFSET: mgmt.rdata = bank.outclk & OUTCLK_KEEP;
      SOFTRST_OFFSET: mgmt.rdata = bank.softrst & SOFTRST_KEEP;
      default: mgmt.rdata = '0;
    endcase
  end

  assign lane_sel = bank.lowside[LANE_SEL_LSB +: 2];
  assign los_ok = bank.lowside[LOS_IGNORE_BIT] | ~|(lane_signal_loss & lane_enable);
  assign lock_ok = bank.lowside[LOCK_IGNORE_BIT] | lowside_pll_lock;

  // Source clocks are foreign, so only the second and third stages feed level and edge logic
  assign src_idx = ccrc_src_index(bank.outclk[SRC_LSB +: 4]);
  assign ratio = ccrc_div_ratio(bank.outclk[DIV_LSB +: 4]);
  assign sel_level = (src_idx == SRC_NONE) ? 1'b0 : bank.src_s2[src_idx];
  assign sel_rise = (src_idx == SRC_NONE) ? 1'b0
                    : (bank.src_s2[src_idx] & ~bank.src_s3[src_idx]);

  ccrc_clk_div #(.CW(5)) u_div (
    .clk(clk),
    .rst(rst),
    .src_level(sel_level),
    .src_rise(sel_rise),
    .ratio(ratio),
    .level(div_level)
  );

  always_comb begin
    next_bank = bank;
    next_bank.src_s1 = source_clocks;
    next_bank.src_s2 = bank.src_s1;
    next_bank.src_s3 = bank.src_s2;
    // A write beats the self-clear landing in the same cycle
    if (mgmt.wr) begin
      case (mgmt.addr)
        LOWSIDE_OFFSET: next_bank.lowside = mgmt.wdata & LOWSIDE_KEEP;
        OUTCLK_OFFSET: next_bank.outclk = mgmt.wdata & OUTCLK_KEEP;
        SOFTRST_OFFSET: next_bank.softrst = mgmt.wdata & SOFTRST_KEEP;
        default: ;
      endcase
    end else if (mgmt.mdc_rise) begin
      next_bank.softrst = bank.softrst & ~SOFTRST_SELF_CLEAR;
    end
    next_bank.rep = lane_status[lane_sel];
    next_bank.link = core_link_ok & los_ok & lock_ok;
    next_bank.realign = bank.lowside[REALIGN_BIT];
    // Datapath reset only leaves the block; registers here stay put
    next_bank.dp_rst = bank.softrst[DATAPATH_RST_BIT];
    // Outside plain 10G the buffers centre themselves, so the pulse is held back
    next_bank.tx_rst = bank.softrst[TX_BUF_RST_BIT] & plain_10g_mode;
    next_bank.rx_rst = bank.softrst[RX_BUF_RST_BIT] & plain_10g_mode;
    next_bank.drv_off = bank.outclk[DRIVER_OFF_BIT];
    if (bank.outclk[DRIVER_OFF_BIT]) begin
      next_bank.pin_p = 1'b0;
      next_bank.pin_n = 1'b0;
    end else if (!bank.outclk[TOGGLE_EN_BIT]) begin
      next_bank.pin_p = 1'b0;
      next_bank.pin_n = 1'b1;
    end else begin
      next_bank.pin_p = div_level;
      next_bank.pin_n = ~div_level;
    end
    if (rst) begin
      next_bank = '0;
      next_bank.lowside = LOWSIDE_RESET;
      next_bank.outclk = OUTCLK_RESET;
      next_bank.softrst = SOFTRST_RESET;
    end
  end

  always_ff @(posedge clk) begin
    bank <= next_bank;
  end

  assign reported_lane_status = bank.rep;
  assign link_status = bank.link;
  assign forced_lane_realign = bank.realign;
  assign datapath_reset = bank.dp_rst;
  assign transmit_buffer_reset = bank.tx_rst;
  assign receive_buffer_reset = bank.rx_rst;
  assign outclk_driver_off = bank.drv_off;
  assign outclk_p = bank.pin_p;
  assign outclk_n = bank.pin_n;

  chk_lane_report: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> reported_lane_status == $past(lane_status[lane_sel]))
    else $error("reported lane status not from selected lane");

  chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    mgmt.wr |=> bank.lowside[11:10] == 2'h0 && !bank.lowside[3])
    else $error("reserved low-side bits held a one");

  chk_loss_ignore: assert property (@(posedge clk) disable iff (rst)
    !bank.lowside[LOS_IGNORE_BIT] && |(lane_signal_loss & lane_enable)
    |=> !link_status)
    else $error("unmasked lane loss did not drop link");

  chk_lock_ignore: assert property (@(posedge clk) disable iff (rst)
    bank.lowside[LOCK_IGNORE_BIT] && !lowside_pll_lock && core_link_ok && los_ok
    |=> link_status)
    else $error("masked pll lock still dropped link");

  chk_realign_level: assert property (@(posedge clk) disable iff (rst)
    $rose(bank.lowside[REALIGN_BIT]) |=> forced_lane_realign)
    else $error("realign request not passed on");

  chk_clock_frozen: assert property (@(posedge clk) disable iff (rst)
    !bank.outclk[TOGGLE_EN_BIT] && !bank.outclk[DRIVER_OFF_BIT]
    ##1 !bank.outclk[TOGGLE_EN_BIT] && !bank.outclk[DRIVER_OFF_BIT]
    |=> !outclk_p && outclk_n && $stable(outclk_p))
    else $error("output clock moved while disabled");

  chk_driver_down: assert property (@(posedge clk) disable iff (rst)
    bank.outclk[DRIVER_OFF_BIT] |=> !outclk_p && !outclk_n && outclk_driver_off)
    else $error("clock driver active while powered down");

  chk_source_none: assert property (@(posedge clk) disable iff (rst)
    bank.outclk[SRC_LSB + 3] |-> !sel_rise && !sel_level)
    else $error("reserved source code selected a clock");

  chk_self_clear: assert property (@(posedge clk) disable iff (rst)
    bank.softrst[DATAPATH_RST_BIT] && mgmt.mdc_rise && !mgmt.wr
    |=> !bank.softrst[DATAPATH_RST_BIT])
    else $error("reset bit did not self-clear");

  chk_dp_reset: assert property (@(posedge clk) disable iff (rst)
    bank.softrst[DATAPATH_RST_BIT] && !mgmt.wr |=> datapath_reset && $stable(bank.lowside))
    else $error("datapath reset missing or disturbed registers");

  chk_buffer_gate: assert property (@(posedge clk) disable iff (rst)
    !plain_10g_mode |=> !transmit_buffer_reset && !receive_buffer_reset)
    else $error("buffer reset issued outside plain 10G mode");

  chk_tx_buffer: assert property (@(posedge clk) disable iff (rst)
    bank.softrst[TX_BUF_RST_BIT] && plain_10g_mode |=> transmit_buffer_reset)
    else $error("transmit buffer reset not issued");

  chk_reset_values: assert property (@(posedge clk)
    rst |=> bank.lowside == LOWSIDE_RESET && bank.outclk == OUTCLK_RESET
    && bank.softrst == SOFTRST_RESET)
    else $error("register reset value wrong");

  chk_link_and: assert property (@(posedge clk) disable iff (rst)
    !core_link_ok |=> !link_status)
    else $error("link up while core indicator is low");

  chk_link_up: assert property (@(posedge clk) disable iff (rst)
    core_link_ok && los_ok && lock_ok
    |=> link_status)
    else $error("link low although every unmasked indicator is good");

  chk_lock_used: assert property (@(posedge clk) disable iff (rst)
    !bank.lowside[LOCK_IGNORE_BIT] && !lowside_pll_lock
    |=> !link_status)
    else $error("unmasked pll loss did not drop link");

  chk_realign_clear: assert property (@(posedge clk) disable iff (rst)
    !bank.lowside[REALIGN_BIT]
    |=> !forced_lane_realign)
    else $error("realign request without register bit");

  chk_toggle_follow: assert property (@(posedge clk) disable iff (rst)
    bank.outclk[TOGGLE_EN_BIT] && !bank.outclk[DRIVER_OFF_BIT]
    |=> outclk_p == $past(div_level) && outclk_n == !$past(div_level))
    else $error("enabled output clock not following divider");

  chk_driver_on: assert property (@(posedge clk) disable iff (rst)
    !bank.outclk[DRIVER_OFF_BIT]
    |=> !outclk_driver_off)
    else $error("clock driver off while bit clear");

  chk_div_unity: assert property (@(posedge clk) disable iff (rst)
    ratio == 5'h01
    |=> div_level == $past(sel_level))
    else $error("divide by one not following source");

  chk_src_hs_rec: assert property (@(posedge clk) disable iff (rst)
    bank.outclk[SRC_LSB +: 4] inside {4'h0, 4'h2}
    |-> sel_level == bank.src_s2[0])
    else $error("recovered high-speed clock not selected");

  chk_src_hs_tx: assert property (@(posedge clk) disable iff (rst)
    bank.outclk[SRC_LSB +: 4] inside {4'h1, 4'h3}
    |-> sel_level == bank.src_s2[1])
    else $error("transmit high-speed clock not selected");

  chk_src_vco: assert property (@(posedge clk) disable iff (rst)
    bank.outclk[SRC_LSB +: 4] inside {4'h4, 4'h5}
    |-> sel_level == bank.src_s2[2])
    else $error("vco clock not selected");

  chk_src_ls_rec: assert property (@(posedge clk) disable iff (rst)
    bank.outclk[SRC_LSB +: 4] == 4'h6
    |-> sel_level == bank.src_s2[3])
    else $error("recovered low-speed clock not selected");

  chk_src_ls_tx: assert property (@(posedge clk) disable iff (rst)
    bank.outclk[SRC_LSB +: 4] == 4'h7
    |-> sel_level == bank.src_s2[4])
    else $error("transmit low-speed clock not selected");

  chk_lowside_store: assert property (@(posedge clk) disable iff (rst)
    mgmt.wr && mgmt.addr == LOWSIDE_OFFSET
    |=> bank.lowside == ($past(mgmt.wdata) & LOWSIDE_KEEP))
    else $error("low-side write not stored as masked");

  chk_write_wins: assert property (@(posedge clk) disable iff (rst)
    mgmt.wr && mgmt.addr == SOFTRST_OFFSET
    |=> bank.softrst == ($past(mgmt.wdata) & SOFTRST_KEEP))
    else $error("reset register write lost");

  chk_clear_keeps: assert property (@(posedge clk) disable iff (rst)
    mgmt.mdc_rise && !mgmt.wr
    |=> bank.softrst[DATAPATH_RST_BIT:RX_BUF_RST_BIT] == 3'h0 && $stable(bank.softrst[7:4]))
    else $error("self-clear missed or disturbed stored bits");

  chk_rx_buffer: assert property (@(posedge clk) disable iff (rst)
    bank.softrst[RX_BUF_RST_BIT] && plain_10g_mode
    |=> receive_buffer_reset)
    else $error("receive buffer reset not issued");
endmodule : ccrc_top
`default_nettype wire
